// ==== hw/ubl_defines.vh ====
`ifndef UBL_DEFINES_VH
`define UBL_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UBL_OFF_CMD 8'h00
`define UBL_OFF_MODE 8'h04
`define UBL_OFF_THR 8'h08
`define UBL_OFF_STAT 8'h0c
`define UBL_OFF_INTST 8'h10
`define UBL_OFF_INTMSK 8'h14
`define UBL_OFF_LINM 8'h18
`define UBL_OFF_LINID 8'h1c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UBL_CMD_STT 0
`define UBL_CMD_STP 1
`define UBL_MODE_TG_LSB 16
`define UBL_MODE_PAR 24
`define UBL_LINM_EN 0
`define UBL_LINM_CKD 4
`define UBL_LINM_CKT 5
`define UBL_LINM_DLM 8
`define UBL_LINM_DLC_LSB 16
`define UBL_INT_BRKEND 0
`define UBL_INT_FRMEND 1
`define UBL_INT_CHREND 2

// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define UBL_DIV_RST 16'h0010
`define UBL_TG_RST 8'h00
`define UBL_GUARD_MIN 8'h0c
`define UBL_CHAR_BITS 8'h0a
`define UBL_BRK_FILL 8'h00
`define UBL_LEN_2 9'h002
`define UBL_LEN_4 9'h004
`define UBL_LEN_8 9'h008

`endif

// ==== hw/ubl_tx_shift.v ====
`timescale 1ns/1ps
module ubl_tx_shift (
  input wire clk, // Peripheral clock
  input wire rstn, // Async reset, active low
  input wire bit_tick, // One pulse per bit time
  input wire load, // Load a character
  input wire [7:0] data, // Character to send
  input wire par_en, // Even parity bit enable
  output wire busy, // Character in flight
  output wire txd, // Serial line level
  output wire done // Last bit finished, pulse
);

reg [10:0] sh_ff;
reg [3:0] cnt_ff;

// ----------------------------------------
// Shift register, LSB first, idle high
// ----------------------------------------
always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    sh_ff <= 11'h7ff;
    cnt_ff <= 4'h0;
  end else if (load) begin
    sh_ff <= {1'b1, (par_en ? ^data : 1'b1), data, 1'b0};
    cnt_ff <= par_en ? 4'hb : 4'ha;
  end else if (bit_tick && cnt_ff != 4'h0) begin
    sh_ff <= {1'b1, sh_ff[10:1]};
    cnt_ff <= cnt_ff - 4'h1;
  end
end

// Status and line
assign busy = (cnt_ff != 4'h0);
assign txd = sh_ff[0];
assign done = bit_tick && (cnt_ff == 4'h1);

endmodule // ubl_tx_shift

// ==== hw/ubl_lin_calc.v ====
`timescale 1ns/1ps
`include "ubl_defines.vh"
module ubl_lin_calc (
  input wire clk, // Peripheral clock
  input wire rstn, // Async reset, active low
  input wire clr, // Start a new sum
  input wire [7:0] seed, // First term of the sum
  input wire add, // Add one data byte
  input wire [7:0] byte_in, // Data byte
  input wire length_mode_sel, // Length from identifier
  input wire [7:0] length_count, // Programmed count
  input wire [7:0] frame_identifier, // Protected identifier
  output wire [8:0] resp_len, // Data bytes, no checksum
  output wire [7:0] checksum // Inverted sum
);

reg [7:0] sum_ff;
reg [8:0] id_len;
wire [8:0] s9;
wire [7:0] nxt_sum;

// ----------------------------------------
// Sum with end-around carry
// ----------------------------------------
assign s9 = {1'b0, sum_ff} + {1'b0, byte_in};
assign nxt_sum = s9[7:0] + {7'h00, s9[8]};

always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    sum_ff <= 8'h00;
  end else if (clr) begin
    sum_ff <= seed;
  end else if (add) begin
    sum_ff <= nxt_sum;
  end
end

assign checksum = ~sum_ff;

// ----------------------------------------
// Response data length
// ----------------------------------------
always @* begin
  case (frame_identifier[5:4])
    2'b10: id_len = `UBL_LEN_4;
    2'b11: id_len = `UBL_LEN_8;
    default: id_len = `UBL_LEN_2;
  endcase
end

// Data bytes only, checksum not counted
assign resp_len = length_mode_sel ? id_len : ({1'b0, length_count} + 9'h001);

endmodule // ubl_lin_calc

// ==== hw/ubl_top.v ====
`timescale 1ns/1ps
`include "ubl_defines.vh"
module ubl_top (
  input wire pclk, // APB clock, 40 MHz
  input wire presetn, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error, unmapped
  output reg txd, // Serial output line
  output reg irq // Level interrupt
);

// ----------------------------------------
// Transmit states
// ----------------------------------------
localparam S_IDLE = 2'b00;
localparam S_BRK = 2'b01;
localparam S_GUARD = 2'b10;

reg [15:0] div_ff;
reg [7:0] tg_ff;
reg par_en_ff;
reg lin_en_ff;
reg ckd_ff;
reg ckt_ff;
reg dlm_ff;
reg [7:0] dlc_ff;
reg [7:0] id_ff;
reg [7:0] hold_ff;
reg hold_vld_ff;
reg brk_pend_ff;
reg brk_stop_ff;
reg [1:0] state_ff;
reg [7:0] bcnt_ff;
reg [15:0] baud_cnt_ff;
reg tick_ff;
reg frm_act_ff;
reg chk_pend_ff;
reg [8:0] fcnt_ff;
reg [2:0] int_st_ff;
reg [2:0] int_msk_ff;
reg [31:0] rd_mux;
reg rd_err;

wire setup;
wire acc;
wire wr;
wire sh_busy;
wire sh_txd;
wire sh_done;
wire [8:0] resp_len;
wire [7:0] checksum;
wire tx_holding_free;
wire tx_all_empty;
wire start_break_cmd;
wire stop_break_cmd;
wire wr_thr;
wire wr_id;
wire can_load;
wire ld_chk;
wire ld_hold;
wire sh_load;
wire [7:0] sh_data;
wire [7:0] char_bits;
wire [7:0] guard_len;
wire brk_end;
wire frm_end;
wire [2:0] ev;
wire [2:0] nxt_int_st;

// ----------------------------------------
// APB decode
// ----------------------------------------
assign setup = psel && !penable;
assign acc = psel && penable && pready;
assign wr = acc && pwrite && !pslverr;
assign wr_thr = wr && (paddr == `UBL_OFF_THR);
assign wr_id = wr && (paddr == `UBL_OFF_LINID);

// Read data and address check
always @* begin
  rd_mux = 32'h00000000;
  rd_err = 1'b0;
  case (paddr)
    `UBL_OFF_CMD: rd_mux = 32'h00000000;
    `UBL_OFF_MODE: rd_mux = {7'h00, par_en_ff, tg_ff, div_ff};
    `UBL_OFF_THR: rd_mux = 32'h00000000;
    `UBL_OFF_STAT: rd_mux = {28'h0000000, frm_act_ff, (state_ff == S_BRK), tx_all_empty, tx_holding_free};
    `UBL_OFF_INTST: rd_mux = {29'h00000000, int_st_ff};
    `UBL_OFF_INTMSK: rd_mux = {29'h00000000, int_msk_ff};
    `UBL_OFF_LINM: rd_mux = {8'h00, dlc_ff, 7'h00, dlm_ff, 2'h0, ckt_ff, ckd_ff, 3'h0, lin_en_ff};
    `UBL_OFF_LINID: rd_mux = {24'h000000, id_ff};
    default: rd_err = 1'b1;
  endcase
end

// No wait state: answer prepared in setup cycle
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    pready <= 1'b0;
    pslverr <= 1'b0;
    prdata <= 32'h00000000;
  end else begin
    pready <= setup;
    pslverr <= setup && rd_err;
    prdata <= (setup && !pwrite) ? rd_mux : 32'h00000000;
  end
end

// ----------------------------------------
// Configuration registers
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    div_ff <= `UBL_DIV_RST;
    tg_ff <= `UBL_TG_RST;
    par_en_ff <= 1'b0;
    lin_en_ff <= 1'b0;
    ckd_ff <= 1'b0;
    ckt_ff <= 1'b0;
    dlm_ff <= 1'b0;
    dlc_ff <= 8'h00;
    id_ff <= 8'h00;
    int_msk_ff <= 3'h0;
  end else if (wr) begin
    if (paddr == `UBL_OFF_MODE) begin
      div_ff <= pwdata[15:0];
      tg_ff <= pwdata[`UBL_MODE_TG_LSB+7:`UBL_MODE_TG_LSB];
      par_en_ff <= pwdata[`UBL_MODE_PAR];
    end
    if (paddr == `UBL_OFF_LINM) begin
      lin_en_ff <= pwdata[`UBL_LINM_EN];
      ckd_ff <= pwdata[`UBL_LINM_CKD];
      ckt_ff <= pwdata[`UBL_LINM_CKT];
      dlm_ff <= pwdata[`UBL_LINM_DLM];
      dlc_ff <= pwdata[`UBL_LINM_DLC_LSB+7:`UBL_LINM_DLC_LSB];
    end
    if (paddr == `UBL_OFF_INTMSK) begin
      int_msk_ff <= pwdata[2:0];
    end
    if (wr_id) begin
      id_ff <= pwdata[7:0];
    end
  end
end

// ----------------------------------------
// Bit-time divider
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    baud_cnt_ff <= 16'h0000;
    tick_ff <= 1'b0;
  end else if (div_ff == 16'h0000) begin
    baud_cnt_ff <= 16'h0000;
    tick_ff <= 1'b0;
  end else if (baud_cnt_ff >= div_ff - 16'h0001) begin
    baud_cnt_ff <= 16'h0000;
    tick_ff <= 1'b1;
  end else begin
    baud_cnt_ff <= baud_cnt_ff + 16'h0001;
    tick_ff <= 1'b0;
  end
end

// ----------------------------------------
// Flags and command acceptance
// ----------------------------------------
// A pending break occupies the holding slot like a character
assign tx_holding_free = !hold_vld_ff && !brk_pend_ff;
assign tx_all_empty = tx_holding_free && !sh_busy && (state_ff == S_IDLE) && !chk_pend_ff;

// Start taken only with holding free and no break in progress
assign start_break_cmd = wr && (paddr == `UBL_OFF_CMD) && pwdata[`UBL_CMD_STT] && tx_holding_free &&
                         !brk_pend_ff && (state_ff == S_IDLE);
// Stop needs an accepted start; ignored when sent with start
assign stop_break_cmd = wr && (paddr == `UBL_OFF_CMD) && pwdata[`UBL_CMD_STP] && !pwdata[`UBL_CMD_STT] &&
                        tx_holding_free && (brk_pend_ff || state_ff == S_BRK);

// ----------------------------------------
// Shifter load selection
// ----------------------------------------
// Load on a bit tick so that the start bit lasts a whole bit time
assign can_load = (state_ff == S_IDLE) && !sh_busy && !brk_pend_ff && tick_ff;
assign ld_chk = can_load && chk_pend_ff;
assign ld_hold = can_load && !chk_pend_ff && hold_vld_ff;
assign sh_load = ld_chk || ld_hold;
assign sh_data = ld_chk ? checksum : hold_ff;

// Holding register; writes dropped while a break is pending
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    hold_ff <= 8'h00;
    hold_vld_ff <= 1'b0;
  end else if (wr_thr && tx_holding_free) begin
    hold_ff <= pwdata[7:0];
    hold_vld_ff <= 1'b1;
  end else if (ld_hold) begin
    hold_vld_ff <= 1'b0;
  end
end

// ----------------------------------------
// Break sequencer
// ----------------------------------------
assign char_bits = par_en_ff ? (`UBL_CHAR_BITS + 8'h01) : `UBL_CHAR_BITS;
assign guard_len = (tg_ff > `UBL_GUARD_MIN) ? tg_ff : `UBL_GUARD_MIN;
assign brk_end = (state_ff == S_GUARD) && (bcnt_ff > guard_len);

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    state_ff <= S_IDLE;
    bcnt_ff <= 8'h00;
    brk_pend_ff <= 1'b0;
    brk_stop_ff <= 1'b0;
  end else begin
    if (stop_break_cmd) begin
      brk_stop_ff <= 1'b1;
    end
    case (state_ff)
      S_IDLE: begin
        if (start_break_cmd) begin
          brk_pend_ff <= 1'b1;
        end else if (brk_pend_ff && !sh_busy) begin
          // Break starts after the character in flight
          brk_pend_ff <= 1'b0;
          bcnt_ff <= 8'h00;
          state_ff <= S_BRK;
        end
      end
      S_BRK: begin
        // Whole bit times counted; the first tick may be partial
        if (tick_ff && bcnt_ff <= char_bits) begin
          bcnt_ff <= bcnt_ff + 8'h01;
        end
        if ((brk_stop_ff || stop_break_cmd) && bcnt_ff > char_bits) begin
          brk_stop_ff <= 1'b0;
          bcnt_ff <= 8'h00;
          state_ff <= S_GUARD;
        end
      end
      S_GUARD: begin
        if (tick_ff) begin
          bcnt_ff <= bcnt_ff + 8'h01;
        end
        if (brk_end) begin
          bcnt_ff <= 8'h00;
          state_ff <= S_IDLE;
        end
      end
      default: begin
        state_ff <= S_IDLE;
      end
    endcase
  end
end

// ----------------------------------------
// LIN response framing
// ----------------------------------------
assign frm_end = (frm_act_ff && fcnt_ff == resp_len) || ld_chk;

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    frm_act_ff <= 1'b0;
    chk_pend_ff <= 1'b0;
    fcnt_ff <= 9'h000;
  end else if (wr_id && lin_en_ff) begin
    frm_act_ff <= 1'b1;
    chk_pend_ff <= 1'b0;
    fcnt_ff <= 9'h000;
  end else if (frm_act_ff && fcnt_ff == resp_len) begin
    // Checksum follows the last data byte unless disabled
    frm_act_ff <= 1'b0;
    chk_pend_ff <= !ckd_ff;
  end else if (ld_chk) begin
    chk_pend_ff <= 1'b0;
  end else if (ld_hold && frm_act_ff) begin
    fcnt_ff <= fcnt_ff + 9'h001;
  end
end

// Enhanced seeds the sum with the identifier, classic with zero
ubl_lin_calc u_calc (
  .clk(pclk),
  .rstn(presetn),
  .clr(wr_id),
  .seed(pwdata[7:0] & {8{!ckt_ff}}),
  .add(ld_hold && frm_act_ff),
  .byte_in(hold_ff),
  .length_mode_sel(dlm_ff),
  .length_count(dlc_ff),
  .frame_identifier(id_ff),
  .resp_len(resp_len),
  .checksum(checksum)
);

// ----------------------------------------
// Character shifter
// ----------------------------------------
ubl_tx_shift u_shift (
  .clk(pclk),
  .rstn(presetn),
  .bit_tick(tick_ff),
  .load(sh_load),
  .data(sh_data),
  .par_en(par_en_ff),
  .busy(sh_busy),
  .txd(sh_txd),
  .done(sh_done)
);

// Line low for the whole break, like a zero character
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    txd <= 1'b1;
  end else if (state_ff == S_BRK) begin
    txd <= ^`UBL_BRK_FILL;
  end else begin
    txd <= sh_txd;
  end
end

// ----------------------------------------
// Interrupt status, write one to clear
// ----------------------------------------
assign ev = {sh_done, frm_end && !(frm_act_ff && !ckd_ff && fcnt_ff == resp_len), brk_end};
assign nxt_int_st = (int_st_ff & ~((wr && paddr == `UBL_OFF_INTST) ? pwdata[2:0] : 3'h0)) | ev;

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    int_st_ff <= 3'h0;
    irq <= 1'b0;
  end else begin
    int_st_ff <= nxt_int_st;
    irq <= |(nxt_int_st & int_msk_ff);
  end
end

endmodule // ubl_top

// ==== tb/ubl_checker.sv ====
`timescale 1ns/1ps
module ubl_checker (
  input logic pclk, // Clock
  input logic presetn, // Reset, active low
  input logic psel, // Select
  input logic penable, // Access phase
  input logic pwrite, // Direction
  input logic [7:0] paddr, // Address
  input logic [31:0] pwdata, // Write data
  input logic [31:0] prdata, // Read data
  input logic pready, // Ready
  input logic pslverr, // Error
  input logic txd, // Serial line
  input logic irq // Interrupt
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------
  // Line run lengths
  // ----------------
  logic [15:0] div_ff;
  logic [7:0] tg_ff;
  logic [15:0] lo_ff;
  logic [15:0] hi_ff;
  logic brk_ff;
  logic wr_ok;
  logic [31:0] guard;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign guard = (tg_ff > 8'h0c ? tg_ff : 8'h0c) * div_ff;
  // Snoop bit time, count high and low runs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 16'h0010;
      tg_ff <= 8'h00;
      lo_ff <= 16'h0000;
      hi_ff <= 16'h0000;
      brk_ff <= 1'b0;
    end else begin
      if (wr_ok && paddr == 8'h04) begin
        div_ff <= pwdata[15:0];
        tg_ff <= pwdata[23:16];
      end
      lo_ff <= txd ? 16'h0000 : lo_ff + 16'h0001;
      hi_ff <= txd ? hi_ff + {15'h0000, ~&hi_ff} : 16'h0000;
      brk_ff <= txd ? brk_ff : (lo_ff >= 10 * div_ff);
    end
  end
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_refused: assert property (psel && !penable && paddr > 8'h1c |=> pslverr)
    else $error("unmapped access not refused");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h00000000)
    else $error("read data not zero outside access");
  a_cmd_reads_zero: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata == 32'h00000000)
    else $error("command register reads nonzero");
  a_mask_off_quiet: assert property (wr_ok && paddr == 8'h14 && pwdata[2:0] == 3'h0 |-> ##2 !irq)
    else $error("interrupt with all masked");
  a_guard_after_brk: assert property ($fell(txd) && brk_ff |-> hi_ff >= guard)
    else $error("guard after break too short");
  c_break_seen: cover property ($rose(brk_ff));
  c_refused: cover property (pslverr);
  c_irq_up: cover property ($rose(irq));
endmodule // ubl_checker
bind ubl_top ubl_checker ubl_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .txd(txd), .irq(irq));

// ==== tb/ubl_rx_model.sv ====
`timescale 1ns/1ps
module ubl_rx_model #(
  parameter int DIV = 4 // Pclk cycles per bit
) (
  input logic clk, // Sampling clock
  input logic line // Serial line
);
  logic [7:0] got[$];
  logic [7:0] b;
  int breaks = 0;
  int brk_len = 0;
  int n;
  // Sample mid-bit from the start edge; zero data with low stop is a break
  initial begin
    forever begin
      @(negedge line);
      repeat (DIV / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(negedge clk);
        b[i] = line;
      end
      repeat (DIV) @(negedge clk);
      if (line === 1'b0 && b === 8'h00) begin
        n = DIV / 2 + 9 * DIV;
        while (line === 1'b0) begin
          @(negedge clk);
          n++;
        end
        breaks++;
        brk_len = n;
      end else begin
        got.push_back(b);
      end
    end
  end
endmodule // ubl_rx_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  localparam int DIV = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, txd, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0] d[256];
  int failures = 0;
  int checks_done = 0;
  ubl_top ubl_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txd(txd), .irq(irq));
  ubl_rx_model #(.DIV(DIV)) ubl_rx_model_inst (.clk(pclk), .line(txd));
  // Clock, 25 ns
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ----------------
  // Shared tasks
  // ----------------
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick_out();
    failures++;
    $display("Error %0t wait ran out", $time);
    give_verdict();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) tick_out();
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask
  task automatic take(input logic [7:0] exp);
    int k;
    for (k = 0; k < 4000 && ubl_rx_model_inst.got.size() == 0; k++) @(posedge pclk);
    if (k == 4000) tick_out();
    chk({24'h000000, ubl_rx_model_inst.got.pop_front()}, {24'h000000, exp});
  endtask
  // Reset values, unmapped access, bit time setup
  task automatic t_regs();
    rd(8'h04);
    chk(r, 32'h00000010);
    rd(8'h0c);
    chk(r, 32'h00000003);
    rd(8'h00);
    chk(r, 32'h00000000);
    rd(8'h20);
    chk({r[31:1], r[0] | err}, 32'h00000001);
    wr(8'h04, 32'h00140004);
    rd(8'h04);
    chk(r, 32'h00140004);
  endtask
  // Break over a character in flight, with guard and interrupt
  task automatic t_break();
    int k;
    wr(8'h14, 32'h00000000);
    wr(8'h08, 32'h00000055);
    wr(8'h00, 32'h00000001);
    rd(8'h0c);
    chk(r, 32'h00000000);
    wr(8'h08, 32'h000000a5);
    take(8'h55);
    for (k = 0; k < 400; k++) begin
      rd(8'h0c);
      if (r[2] === 1'b1) break;
    end
    if (k == 400) tick_out();
    chk(r, 32'h00000005);
    chk({31'h0, irq}, 32'h00000000);
    wr(8'h14, 32'h00000001);
    wr(8'h00, 32'h00000001);
    wr(8'h00, 32'h00000002); // Stop alone
    wr(8'h08, 32'h0000003b);
    for (k = 0; k < 4000 && irq !== 1'b1; k++) @(posedge pclk);
    if (k == 4000) tick_out();
    chk(ubl_rx_model_inst.brk_len >= 10 * DIV, 1);
    rd(8'h10);
    chk(r & 32'h00000001, 32'h00000001);
    wr(8'h10, 32'h00000007);
    rd(8'h10);
    chk({r[31:1], r[0] | irq}, 32'h00000000);
    take(8'h3b);
    wr(8'h00, 32'h00000002);
    wr(8'h08, 32'h00000077);
    take(8'h77);
    chk(ubl_rx_model_inst.breaks, 1);
  endtask
  // One response frame, checksum worked out here
  task automatic t_lin(input logic [31:0] mode, input logic [7:0] id, input int n, input logic enh,
                       input logic ck);
    int s;
    int k;
    for (k = 0; k < n; k++) d[k] = 8'h11 + 8'h22 * k[7:0];
    forever begin
      s = enh ? id : 0;
      for (k = 0; k < n; k++) s = (s + d[k] > 255) ? s + d[k] - 255 : s + d[k];
      if (s % 2 == 0) break;
      d[n - 1] = d[n - 1] + 8'h02;
    end
    wr(8'h18, mode);
    wr(8'h1c, {24'h000000, id});
    rd(8'h0c);
    chk(r & 32'h00000008, 32'h00000008);
    for (k = 0; k < n; k++) begin
      wr(8'h08, {24'h000000, d[k]});
      take(d[k]);
    end
    if (ck) take(~s[7:0]);
    repeat (20 * DIV) @(posedge pclk);
    chk(ubl_rx_model_inst.got.size(), 0);
    rd(8'h10);
    chk(r & 32'h00000006, 32'h00000006);
    wr(8'h10, 32'h00000007);
  endtask
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_break();
    t_lin(32'h00000001, 8'h3c, 1, 1'b1, 1'b1);
    t_lin(32'h00ff0021, 8'h47, 256, 1'b0, 1'b1);
    t_lin(32'h00000101, 8'h05, 2, 1'b1, 1'b1);
    t_lin(32'h00000121, 8'h1a, 2, 1'b0, 1'b1);
    t_lin(32'h00000101, 8'h2c, 4, 1'b1, 1'b1);
    t_lin(32'h00770111, 8'h33, 8, 1'b1, 1'b0);
    give_verdict();
  end
endmodule // testbench
